//--- rtl/up_pkg.sv
package up_pkg;
   localparam int UP_CLK_HZ = 10_000_000;
   localparam int UP_BAUD = 9600;
   localparam int UP_OVERSAMPLE = 16;
   // Rounded down; 65 cycles per tick gives about 0.2 percent rate error
   localparam logic [15:0] UP_OS_DIV =
      16'(UP_CLK_HZ / (UP_BAUD * UP_OVERSAMPLE));
   localparam int UP_DW = 8;
   localparam int UP_CW = $clog2(UP_DW);
   localparam logic [UP_CW-1:0] UP_LAST_BIT = UP_CW'(UP_DW - 1);
   localparam logic [3:0] UP_OS_MID = 4'h7;
   localparam logic [3:0] UP_OS_END = 4'hf;
   localparam logic [1:0] UP_Q_DEPTH = 2'h2;
   localparam logic [1:0] UP_RTS_LEVEL = 2'h1;

   typedef enum logic [2:0] {
      UP_TX_IDLE, UP_TX_DATA, UP_TX_PAR, UP_TX_STOP
   } up_tx_st_t;

   typedef enum logic [2:0] {
      UP_RX_IDLE, UP_RX_START, UP_RX_DATA, UP_RX_PAR, UP_RX_STOP
   } up_rx_st_t;

   typedef struct packed {
      logic tx_en;      // Transmitter enabled
      logic loopback;   // Local loopback
      logic cts_en;     // Honour clear_to_send_in
      logic rts_auto;   // RTS follows receive_queue fill
      logic rts_manual; // RTS level when not automatic
      logic par_en;     // Parity bit present
      logic par_odd;    // Odd parity when set
      logic stop2;      // Two stop bits
      logic pd_req;     // Power-down request
   } up_ctrl_t;

   typedef struct packed {
      logic [UP_DW-1:0] data;
   } up_tx_word_t;

   typedef struct packed {
      logic [UP_DW-1:0] data;
      logic par_err;
   } up_rx_word_t;

   typedef struct packed {
      logic run;
      logic [15:0] div;
      logic [3:0] tx_os;
      logic sclk;
      up_tx_st_t tx_st;
      logic [UP_DW-1:0] tx_sh;
      logic [UP_CW-1:0] tx_cnt;
      logic tx_par;
      logic tx_two;
      logic tx_bit;
      logic tx_line;
      logic [UP_DW-1:0] hold;
      logic hold_v;
      logic tx_ready;
      up_rx_st_t rx_st;
      logic [3:0] rx_os;
      logic [UP_CW-1:0] rx_cnt;
      logic [UP_DW-1:0] rx_sh;
      logic rx_par;
      logic rx_perr;
      logic rx_prev;
      up_rx_word_t [1:0] q_mem;
      logic q_wr;
      logic q_rd;
      logic [1:0] q_cnt;
      logic rx_valid;
      up_rx_word_t rx_out;
      logic ferr;
      logic ovr;
      logic rts;
   } up_state_t;

   localparam up_state_t UP_STATE_RST = '{
      run: 1'b1, tx_bit: 1'b1, tx_line: 1'b1, tx_ready: 1'b1,
      rx_prev: 1'b1, tx_st: UP_TX_IDLE, rx_st: UP_RX_IDLE,
      default: '0};
endpackage : up_pkg

//--- rtl/up_uart.sv
`timescale 1ns/1ns
module up_uart #(
   parameter logic [15:0] BAUD_DIV = up_pkg::UP_OS_DIV,
   parameter logic [1:0] RTS_LEVEL = up_pkg::UP_RTS_LEVEL
) (
   input wire logic core_clk,                 // 10 MHz clock
   input wire logic rst,                      // Sync reset, active high
   input wire up_pkg::up_ctrl_t ctrl,         // Static configuration
   input wire logic tx_valid,                 // Word offered to send
   input wire up_pkg::up_tx_word_t tx_word,   // Word to send
   output logic tx_ready,                     // Holding slot free
   output logic serial_tx_line,               // Serial data out
   input wire logic serial_rx_line,           // Serial data in
   input wire logic clear_to_send_in,         // Remote allows sending
   output logic request_to_send_out,          // Remote may send
   output logic rx_valid,                     // receive_queue head valid
   output up_pkg::up_rx_word_t rx_word,       // receive_queue head
   input wire logic rx_ready,                 // Consumer takes head
   output logic rx_frame_err,                 // Bad stop bit, pulse
   output logic rx_overrun,                   // Word lost, pulse
   output logic serial_clk_run                // Serial clock running
);
   import up_pkg::*;

   if (BAUD_DIV < 16'h0002) begin : g_bad_div
      $error("BAUD_DIV must be at least 2");
   end
   if (RTS_LEVEL == 2'h0 || RTS_LEVEL > UP_Q_DEPTH) begin : g_bad_rts
      $error("RTS_LEVEL must be 1 to queue depth");
   end

   up_state_t s;
   up_state_t n;
   logic rin;
   logic rin_edge;
   logic os_tick;
   logic fall;
   logic start_go;
   logic rx_samp;
   logic push;
   logic pop;
   logic live;

   // Loopback feeds the transmitter's bit straight into the receiver
   assign rin = ctrl.loopback ? s.tx_bit : serial_rx_line;
   assign rin_edge = rin != s.rx_prev;
   assign live = ctrl.tx_en && !ctrl.loopback;

   always_comb begin
      n = s;
      start_go = 1'b0;
      rx_samp = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      n.ferr = 1'b0;
      n.ovr = 1'b0;
      n.rx_prev = rin;
      os_tick = s.run && (s.div == BAUD_DIV - 16'h0001);
      if (os_tick) begin
         n.div = '0;
         n.tx_os = s.tx_os + 4'h1;
      end else if (s.run) begin
         n.div = s.div + 16'h0001;
      end
      n.sclk = n.tx_os[3];
      fall = os_tick && (s.tx_os == UP_OS_END);
      // Serial clock halts only when both directions are quiet
      if (ctrl.pd_req && s.run && s.tx_st == UP_TX_IDLE && !s.hold_v &&
          s.rx_st == UP_RX_IDLE && rin) begin
         n.run = 1'b0;
      end
      if (!s.run && (rin_edge || !ctrl.pd_req)) begin
         n.run = 1'b1;
      end

      if (tx_valid && s.tx_ready) begin
         n.hold = tx_word.data;
         n.hold_v = 1'b1;
      end
      if (!ctrl.tx_en) begin
         n.tx_st = UP_TX_IDLE;
         n.tx_bit = 1'b1;
      end else if (fall) begin
         case (s.tx_st)
            UP_TX_IDLE: begin
               if (s.hold_v &&
                   (!ctrl.cts_en || clear_to_send_in)) begin
                  start_go = 1'b1;
                  n.tx_bit = 1'b0;
                  n.tx_sh = s.hold;
                  n.hold_v = 1'b0;
                  n.tx_cnt = '0;
                  n.tx_par = ctrl.par_odd;
                  n.tx_st = UP_TX_DATA;
               end
            end
            UP_TX_DATA: begin
               n.tx_bit = s.tx_sh[0];
               n.tx_sh = s.tx_sh >> 1;
               n.tx_par = s.tx_par ^ s.tx_sh[0];
               n.tx_cnt = s.tx_cnt + 1'b1;
               if (s.tx_cnt == UP_LAST_BIT) begin
                  n.tx_st = ctrl.par_en ? UP_TX_PAR : UP_TX_STOP;
                  n.tx_two = ctrl.stop2;
               end
            end
            UP_TX_PAR: begin
               n.tx_bit = s.tx_par;
               n.tx_st = UP_TX_STOP;
               n.tx_two = ctrl.stop2;
            end
            UP_TX_STOP: begin
               n.tx_bit = 1'b1;
               if (s.tx_two) begin
                  n.tx_two = 1'b0;
               end else begin
                  n.tx_st = UP_TX_IDLE;
               end
            end
            default: begin
               n.tx_st = UP_TX_IDLE;
            end
         endcase
      end
      n.tx_line = live ? n.tx_bit : 1'b1;
      n.tx_ready = !n.hold_v;

      if (os_tick) begin
         n.rx_os = s.rx_os + 4'h1;
         case (s.rx_st)
            UP_RX_IDLE: begin
               if (!rin) begin
                  n.rx_st = UP_RX_START;
                  n.rx_os = '0;
               end
            end
            UP_RX_START: begin
               // Glitch shorter than half a bit is not a start bit
               if (s.rx_os == UP_OS_MID) begin
                  n.rx_st = rin ? UP_RX_IDLE : UP_RX_DATA;
                  n.rx_os = '0;
                  n.rx_cnt = '0;
                  n.rx_par = ctrl.par_odd;
                  n.rx_perr = 1'b0;
               end
            end
            UP_RX_DATA: begin
               if (s.rx_os == UP_OS_END) begin
                  rx_samp = 1'b1;
                  n.rx_sh = {rin, s.rx_sh[UP_DW-1:1]};
                  n.rx_par = s.rx_par ^ rin;
                  n.rx_cnt = s.rx_cnt + 1'b1;
                  if (s.rx_cnt == UP_LAST_BIT) begin
                     n.rx_st = ctrl.par_en ? UP_RX_PAR : UP_RX_STOP;
                  end
               end
            end
            UP_RX_PAR: begin
               if (s.rx_os == UP_OS_END) begin
                  n.rx_perr = s.rx_par != rin;
                  n.rx_st = UP_RX_STOP;
               end
            end
            UP_RX_STOP: begin
               if (s.rx_os == UP_OS_END) begin
                  n.rx_st = UP_RX_IDLE;
                  push = rin;
                  n.ferr = !rin;
               end
            end
            default: begin
               n.rx_st = UP_RX_IDLE;
            end
         endcase
      end

      pop = s.rx_valid && rx_ready;
      if (pop) begin
         n.q_rd = !s.q_rd;
      end
      // A word arriving while full is dropped unless the head leaves now
      if (push && (s.q_cnt != UP_Q_DEPTH || pop)) begin
         n.q_mem[s.q_wr] = '{data: s.rx_sh, par_err: s.rx_perr};
         n.q_wr = !s.q_wr;
         n.q_cnt = pop ? s.q_cnt : s.q_cnt + 2'h1;
      end else begin
         n.ovr = push;
         n.q_cnt = pop ? s.q_cnt - 2'h1 : s.q_cnt;
      end
      n.rx_valid = n.q_cnt != 2'h0;
      n.rx_out = n.q_mem[n.q_rd];
      n.rts = ctrl.rts_auto ? (n.q_cnt < RTS_LEVEL)
                            : ctrl.rts_manual;
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         s <= UP_STATE_RST;
      end else begin
         s <= n;
      end
   end

   assign serial_tx_line = s.tx_line;
   assign request_to_send_out = s.rts;
   assign tx_ready = s.tx_ready;
   assign rx_valid = s.rx_valid;
   assign rx_word = s.rx_out;
   assign rx_frame_err = s.ferr;
   assign rx_overrun = s.ovr;
   assign serial_clk_run = s.run;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   AST_MARK_WHEN_OFF: assert property (
      (!ctrl.tx_en || ctrl.loopback) |=> serial_tx_line)
      else $error("tx line not high while disabled or in loopback");
   AST_MARK_WHEN_IDLE: assert property (
      s.tx_st == UP_TX_IDLE |-> serial_tx_line)
      else $error("tx line not high while idle");
   AST_SHIFT_ON_FALL: assert property (
      $changed(serial_tx_line) && $past(live, 1) && $past(live, 2)
      |-> $past(fall))
      else $error("tx line moved away from a serial clock fall");
   AST_LSB_FIRST_TX: assert property (
      fall && live && s.tx_st == UP_TX_DATA
      |=> serial_tx_line == $past(s.tx_sh[0]))
      else $error("tx data bit is not the shifter LSB");
   AST_LSB_FIRST_RX: assert property (
      rx_samp |=> s.rx_sh[UP_DW-1] == $past(rin)
                  && s.rx_sh[UP_DW-2:0] == $past(s.rx_sh[UP_DW-1:1]))
      else $error("rx bit not shifted in from the top");
   AST_WAKE: assert property (
      !s.run && rin_edge |=> s.run)
      else $error("serial clock did not restart on rx edge");
   AST_CTS_GATE: assert property (
      fall && s.tx_st == UP_TX_IDLE && ctrl.cts_en && !clear_to_send_in
      |=> s.tx_st == UP_TX_IDLE)
      else $error("character started without clear to send");
   AST_RTS_AUTO: assert property (
      !$past(rst) && $past(ctrl.rts_auto)
      |-> request_to_send_out == (s.q_cnt < RTS_LEVEL))
      else $error("automatic rts does not follow queue fill");
   AST_RTS_MANUAL: assert property (
      !$past(rst) && !$past(ctrl.rts_auto)
      |-> request_to_send_out == $past(ctrl.rts_manual))
      else $error("manual rts level not driven");
   AST_START_LOW: assert property (
      start_go && live |=> !serial_tx_line ##1 !serial_tx_line)
      else $error("start bit not low");
   AST_QUEUE_BOUND: assert property (
      s.q_cnt <= UP_Q_DEPTH)
      else $error("receive queue count beyond depth");

   COV_TX_START: cover property (start_go && ctrl.cts_en);
   COV_RX_PUSH: cover property (push && s.q_cnt == 2'h1);
   COV_WAKE: cover property (!s.run ##1 s.run);
   COV_RTS_DROP: cover property (
      ctrl.rts_auto && $fell(request_to_send_out));
endmodule : up_uart

//--- tb/up_remote.sv
`timescale 1ns/1ns
module up_remote #(
   parameter int BIT = 32
) (
   input wire logic core_clk,          // Bench clock
   input wire logic serial_tx_line,    // From device
   output logic serial_rx_line,        // To device
   output logic clear_to_send_in       // Permission to device
);
   logic line_ff = 1'b1;
   logic allow_ff = 1'b1;
   assign serial_rx_line = line_ff;
   assign clear_to_send_in = allow_ff;
   // Bit 0 of f goes out first; the line keeps the last bit afterwards
   task automatic send_bits(input logic [11:0] f, input int nb);
      @(negedge core_clk);
      for (int i = 0; i < nb; i++) begin
         line_ff = f[i];
         repeat (BIT) @(negedge core_clk);
      end
   endtask : send_bits
   task automatic send(input logic [7:0] b);
      send_bits({3'b111, b, 1'b0}, 10);
   endtask : send
   // Samples mid-bit, so small edge jitter is tolerated
   task automatic recv_bits(output logic [23:0] f, input int nb);
      int n;
      n = 0;
      f = '1;
      while (serial_tx_line !== 1'b0 && n < 20000) begin
         @(negedge core_clk);
         n++;
      end
      repeat (BIT / 2) @(negedge core_clk);
      for (int i = 0; i < nb; i++) begin
         f[i] = serial_tx_line;
         if (i < nb - 1) begin
            repeat (BIT) @(negedge core_clk);
         end
      end
      // A start that never came spoils every bit
      if (n >= 20000) begin
         f = 'x;
      end
   endtask : recv_bits
   task automatic recv(output logic [7:0] b, output logic ok);
      logic [23:0] f;
      recv_bits(f, 10);
      b = f[8:1];
      ok = (f[0] === 1'b0) && (f[9] === 1'b1);
   endtask : recv
endmodule : up_remote

//--- tb/up_uart_bench.sv
`timescale 1ns/1ns
module up_uart_bench;
   import up_pkg::*;
   localparam int BIT = 32;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   up_ctrl_t ctrl = '0;
   logic tx_valid = 1'b0;
   up_tx_word_t tx_word = '0;
   logic rx_ready = 1'b0;
   logic tx_ready, serial_tx_line, serial_rx_line, clear_to_send_in;
   logic request_to_send_out, rx_valid, rx_frame_err, rx_overrun;
   logic serial_clk_run, ok, ovr_seen, ferr_seen;
   logic [23:0] f;
   up_rx_word_t rx_word;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   logic [31:0] lfsr = 32'h422464e1;
   logic [7:0] b, got, keep [2];
   initial forever #50 core_clk = ~core_clk;
   up_uart #(.BAUD_DIV(16'h0002), .RTS_LEVEL(2'h1)) u_dut (
      .core_clk(core_clk), .rst(rst), .ctrl(ctrl), .tx_valid(tx_valid),
      .tx_word(tx_word), .tx_ready(tx_ready),
      .serial_tx_line(serial_tx_line), .serial_rx_line(serial_rx_line),
      .clear_to_send_in(clear_to_send_in),
      .request_to_send_out(request_to_send_out), .rx_valid(rx_valid),
      .rx_word(rx_word), .rx_ready(rx_ready),
      .rx_frame_err(rx_frame_err), .rx_overrun(rx_overrun),
      .serial_clk_run(serial_clk_run));
   up_remote #(.BIT(BIT)) u_rem (
      .core_clk(core_clk), .serial_tx_line(serial_tx_line),
      .serial_rx_line(serial_rx_line),
      .clear_to_send_in(clear_to_send_in));
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], ^(lfsr & 32'h80200003)};
      return lfsr[7:0];
   endfunction : rnd
   function automatic logic exp_rts(input logic [1:0] cnt);
      return ctrl.rts_auto ? (cnt < UP_RTS_LEVEL) : ctrl.rts_manual;
   endfunction : exp_rts
   // Whole frame with parity and two stops; even parity unless par_odd
   function automatic logic [11:0] frame(input logic [7:0] d);
      return {2'b11, (^d) ^ ctrl.par_odd, d, 1'b0};
   endfunction : frame
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic send_word(input logic [7:0] d);
      int n;
      n = 0;
      @(negedge core_clk);
      tx_valid = 1'b1;
      tx_word.data = d;
      while (tx_ready !== 1'b1 && n < 5000) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 5000) begin
         fail_count++;
      end
      @(negedge core_clk);
      tx_valid = 1'b0;
   endtask : send_word
   task automatic pop(input logic [7:0] d);
      int n;
      n = 0;
      while (rx_valid !== 1'b1 && n < 5000) begin
         @(negedge core_clk);
         n++;
      end
      if (n >= 5000) begin
         fail_count++;
      end
      check(rx_word.data, d);
      rx_ready = 1'b1;
      @(negedge core_clk);
      rx_ready = 1'b0;
   endtask : pop
   task automatic count_lows(input int len);
      int lows;
      lows = 0;
      repeat (len) begin
         @(negedge core_clk);
         lows += (serial_tx_line !== 1'b1);
      end
      check(lows, 0);
   endtask : count_lows
   always @(posedge core_clk) begin
      ovr_seen <= rst ? 1'b0 : (ovr_seen | (rx_overrun === 1'b1));
      ferr_seen <= rst ? 1'b0 : (ferr_seen | (rx_frame_err === 1'b1));
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count++;
         end_of_test();
      end
   end
   initial begin
      repeat (3) @(posedge core_clk);
      @(negedge core_clk) rst = 1'b0;
      count_lows(2 * BIT);
      ctrl.tx_en = 1'b1;
      ctrl.loopback = 1'b1;
      send_word(8'h00);
      count_lows(12 * BIT);
      rst = 1'b1;
      ctrl.loopback = 1'b0;
      repeat (2) @(negedge core_clk);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
         b = (i == 0) ? 8'h01 : rnd();
         fork
            send_word(b);
            u_rem.recv(got, ok);
         join
         check({ok, got}, {1'b1, b});
      end
      ctrl.cts_en = 1'b1;
      u_rem.allow_ff = 1'b0;
      b = rnd();
      send_word(b);
      count_lows(3 * BIT);
      u_rem.allow_ff = 1'b1;
      u_rem.recv(got, ok);
      check({ok, got}, {1'b1, b});
      ctrl.rts_auto = 1'b1;
      // Request-to-send follows the mode one cycle later
      @(negedge core_clk);
      for (int i = 0; i < 3; i++) begin
         b = rnd();
         check(request_to_send_out, exp_rts(2'h0));
         u_rem.send(b);
         check(request_to_send_out, exp_rts(2'h1));
         pop(b);
         repeat (2) @(negedge core_clk);
      end
      ctrl.rts_auto = 1'b0;
      for (int i = 0; i < 2; i++) begin
         ctrl.rts_manual = i[0];
         repeat (2) @(negedge core_clk);
         check(request_to_send_out, exp_rts(2'h0));
      end
      for (int i = 0; i < 3; i++) begin
         keep[i % 2] = (i < 2) ? rnd() : keep[i % 2];
         u_rem.send((i < 2) ? keep[i % 2] : 8'ha5);
      end
      check(ovr_seen, 1'b1);
      pop(keep[0]);
      pop(keep[1]);
      check(rx_valid, 1'b0);
      ctrl.pd_req = 1'b1;
      repeat (5) @(negedge core_clk);
      check(serial_clk_run, 1'b0);
      b = rnd();
      fork
         u_rem.send(b);
         begin
            @(negedge serial_rx_line);
            repeat (2) @(negedge core_clk);
            check(serial_clk_run, 1'b1);
         end
      join
      pop(b);
      ctrl.pd_req = 1'b0;
      // Low stop bit: word dropped, frame error flagged
      b = rnd();
      u_rem.send_bits({2'b11, 1'b0, b, 1'b0}, 11);
      check({ferr_seen, rx_valid}, 2'b10);
      ctrl.par_en = 1'b1;
      ctrl.stop2 = 1'b1;
      ctrl.par_odd = b[0];
      keep[0] = rnd();
      keep[1] = rnd();
      // Back to back: second start must follow the second stop bit
      fork
         begin
            send_word(keep[0]);
            send_word(keep[1]);
         end
         u_rem.recv_bits(f, 24);
      join
      check(f[11:0], frame(keep[0]));
      check(f[23:12], frame(keep[1]));
      for (int i = 0; i < 2; i++) begin
         b = rnd();
         u_rem.send_bits(frame(b) ^ (i[0] ? 12'h200 : 12'h000), 11);
         check(rx_word.par_err, i[0]);
         pop(b);
      end
      end_of_test();
   end
endmodule : up_uart_bench
